//--- ucr_top.sv
// Contract
// - Clear input zeroes counter, aborts measurement, display latches read zero.
// - External window enabled sets measurement length in every function except totalizing.
// - External window sampled once per 10ms reference period only.
// - Sampled window acts at reference period trailing edge, starting or stopping.
// - Status output low during measurement, high between measurements.
// - BCD outputs carry one digit at a time, valid during its strobe.
// - Strobes scan from digit eight down to digit one.
// - BCD lines use plain 8-4-2-1 code, weight eight as MSB.
// - Leading-zero suppression never alters BCD outputs.
// - Decimal point on digits 2 to 5 per range in timing functions, 1 to 4 with the 1MHz timebase.
// - Ratio uses digits 1 to 4, totalizing digit 1, external none.
// - Counter overflow lights decimal point during digit eight strobe.
// - Primary rise before secondary fall returns interval priming to idle.
// - Single-cycle range after priming measures exactly one interval.
// - Repetitive interval timing primes automatically.
// - 200ms update after interval ends before next measurement.
// - Multiplex rate is timebase over 2e4 or 2e3 per mode.
// - Measurement spacing is 2e6 or 2e5 timebase periods per mode.
// - Ratio single-cycle gate spans secondary rise to next rise.
// - Scan at 500Hz, digit on 244us, 6us blank between digits.
// - Interval counts timebase from primary fall to secondary fall.
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`include "ucr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ucr_top
  import ucr_pkg::*;
#(
  parameter int unsigned REF_DIV_10M = `UCR_CLK_HZ / `UCR_REF_HZ,
  parameter int unsigned REF_DIV_1M  = `UCR_OSC1M_HZ / `UCR_REF_HZ,
  parameter int unsigned GAP_10M     = `UCR_GAP_MS * (`UCR_CLK_HZ / 1000),
  parameter int unsigned GAP_1M      = `UCR_GAP_MS * (`UCR_OSC1M_HZ / 1000)
)(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Measurement inputs
  input  wire logic        chanA,
  input  wire logic        chanB,
  input  wire logic        extGateWindow,
  input  wire logic        clearN,
  // Status and display
  output logic             measBusyN,
  output logic [3:0]       bcdOut,
  output logic [7:0]       digitStrobe,
  output logic             dpOut,
  // AXI4-Lite write
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  // ----------------------------------------------------------------
  // Constants and functions
  // ----------------------------------------------------------------
  localparam int unsigned SlotTicks  = `UCR_SLOT_TICKS;
  localparam int unsigned BlankTicks = `UCR_BLANK_TICKS;
  localparam int unsigned LagTicks   = `UCR_LAG_TICKS;
  localparam int unsigned PreDiv     = `UCR_PRE_DIV;
  localparam int LagMinClk = `UCR_LAG_MIN_CLK;
  localparam int LagMaxClk = `UCR_LAG_MAX_CLK;

  // Gate length in reference events per range
  function automatic logic [9:0] rangeTarget(input logic [1:0] rng);
    case (rng)
      2'h0:    rangeTarget = 10'h001;
      2'h1:    rangeTarget = 10'h00A;
      2'h2:    rangeTarget = 10'h064;
      default: rangeTarget = 10'h3E8;
    endcase
  endfunction

  // Decimal point digit, 1 = least significant, 0 = none
  function automatic logic [3:0] dpPosition(input ucr_func_t fn, input logic [1:0] rng,
                                            input logic ext, input logic oneMhz);
    logic [3:0] r;
    r = {2'h0, rng};
    if (ext)
      dpPosition = 4'h0;
    else
      case (fn)
        FN_FREQ, FN_OSC:       dpPosition = r + 4'h2;
        FN_PERIOD, FN_INTERVAL: dpPosition = r + 4'h2 - {3'h0, oneMhz};
        FN_RATIO:              dpPosition = r + 4'h1;
        FN_UNIT:               dpPosition = 4'h1;
        default:               dpPosition = 4'h0;
      endcase
  endfunction

  // One decimal step of the eight-decade counter, carry on top
  function automatic logic [32:0] bcdInc(input logic [31:0] v);
    logic [31:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      if (c)
      begin
        if (r[i*4 +: 4] == 4'h9)
          r[i*4 +: 4] = 4'h0;
        else
        begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    bcdInc = {c, r};
  endfunction

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_ff;
  ucr_state_t  state_ff;
  logic        measBusyN_ff;
  logic [31:0] gapCnt_ff;
  logic [9:0]  evtCnt_ff;
  logic        ivOpen_ff;
  logic [31:0] mainCnt_ff;
  logic        ovf_ff;
  logic [31:0] dispLat_ff;
  logic        ovfLat_ff;
  logic [1:0]  primeStage_ff;
  logic        aPrev_ff, bPrev_ff;
  logic [3:0]  preDiv_ff;
  logic [31:0] refCnt_ff;
  logic        extSample_ff;
  logic [31:0] slotCnt_ff;
  logic [2:0]  scanDigit_ff;
  logic [3:0]  bcdOut_ff;
  logic [7:0]  digitStrobe_ff;
  logic        dpOut_ff;
  logic [7:0]  lagCnt_ff;
  logic        awHeld_ff, wHeld_ff, awReady_ff, wReady_ff, bValid_ff;
  logic [7:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic [1:0]  bResp_ff;
  logic        arReady_ff, rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0]  rResp_ff;

  // Decoded control
  ucr_func_t  func;
  logic [1:0] rangeSel;
  logic       extEn, oneMhz;
  assign func     = ucr_func_t'(ctrl_ff[`UCR_CTRL_FUNC_LSB +: 3]);
  assign rangeSel = ctrl_ff[`UCR_CTRL_RANGE_LSB +: 2];
  assign extEn    = ctrl_ff[`UCR_CTRL_EXTEN_BIT];
  assign oneMhz   = ctrl_ff[`UCR_CTRL_ONEMHZ_BIT];

  // ----------------------------------------------------------------
  // Timebase and 100Hz reference
  // ----------------------------------------------------------------
  logic        tbTick, refTick;
  logic [31:0] refLim, gapLim;
  assign tbTick  = !oneMhz || (preDiv_ff == 4'(PreDiv - 1));
  assign refLim  = oneMhz ? REF_DIV_1M : REF_DIV_10M;
  assign gapLim  = oneMhz ? GAP_1M : GAP_10M;
  assign refTick = tbTick && (refCnt_ff == refLim - 32'h1);

  // Emulated 1MHz timebase and reference divider
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      preDiv_ff <= 4'h0;
      refCnt_ff <= 32'h0;
    end
    else if (ce)
    begin
      preDiv_ff <= tbTick ? 4'h0 : preDiv_ff + 4'h1;
      if (tbTick)
        refCnt_ff <= refTick ? 32'h0 : refCnt_ff + 32'h1;
    end
  end

  // Input edges and window sample record
  logic aFall, bFall, aRise, bRise;
  assign aFall = aPrev_ff && !chanA;
  assign bFall = bPrev_ff && !chanB;
  assign aRise = !aPrev_ff && chanA;
  assign bRise = !bPrev_ff && chanB;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aPrev_ff     <= 1'b0;
      bPrev_ff     <= 1'b0;
      extSample_ff <= 1'b0;
    end
    else if (ce)
    begin
      aPrev_ff <= chanA;
      bPrev_ff <= chanB;
      if (refTick)
        extSample_ff <= extGateWindow;
    end
  end

  // ----------------------------------------------------------------
  // Measurement control
  // ----------------------------------------------------------------
  logic wrFire, restart, refEvt, cntEvt, startCond, stopCond, stopNow;
  assign wrFire  = awHeld_ff && wHeld_ff && !bValid_ff;
  assign restart = wrFire && (awAddr_ff == `UCR_REG_CTRL) && wStrb_ff[0]
                   && (wData_ff[6:0] != ctrl_ff[6:0])
                   && (func != FN_UNIT || wData_ff[2:0] != FN_UNIT); // Leaving unit aborts too

  always_comb
  begin
    case (func)
      FN_FREQ, FN_OSC: refEvt = refTick;
      FN_PERIOD:       refEvt = aRise;
      FN_RATIO:        refEvt = bRise;
      FN_INTERVAL:     refEvt = bFall && ivOpen_ff;
      default:         refEvt = 1'b0;
    endcase
    case (func)
      FN_FREQ, FN_RATIO, FN_UNIT: cntEvt = aRise;
      FN_PERIOD, FN_OSC:          cntEvt = tbTick;
      FN_INTERVAL:                cntEvt = tbTick && ivOpen_ff;
      default:                    cntEvt = 1'b0;
    endcase
    if (extEn && func != FN_UNIT)
    begin
      startCond = refTick && extGateWindow;
      stopCond  = refTick && !extGateWindow;
    end
    else if (func == FN_INTERVAL)
    begin
      startCond = aFall && (primeStage_ff == 2'h2 || rangeSel != 2'h0);
      stopCond  = refEvt && (evtCnt_ff == rangeTarget(rangeSel) - 10'h1);
    end
    else
    begin
      startCond = (func == FN_UNIT) || refEvt;
      stopCond  = (func != FN_UNIT) && refEvt && (evtCnt_ff == rangeTarget(rangeSel) - 10'h1);
    end
  end
  assign stopNow = clearN && !restart && (state_ff == ST_GATE) && stopCond;

  // Sequencer: gap, armed, gating
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff     <= ST_ARMED;
      measBusyN_ff <= 1'b1;
      gapCnt_ff    <= 32'h0;
      evtCnt_ff    <= 10'h0;
      ivOpen_ff    <= 1'b0;
    end
    else if (ce)
    begin
      if (!clearN || restart)
      begin
        state_ff     <= ST_ARMED;
        measBusyN_ff <= 1'b1;
        gapCnt_ff    <= 32'h0;
        evtCnt_ff    <= 10'h0;
        ivOpen_ff    <= 1'b0;
      end
      else
        case (state_ff)
          ST_GAP:
          begin
            if (tbTick)
              gapCnt_ff <= gapCnt_ff + 32'h1;
            if (tbTick && gapCnt_ff == gapLim - 32'h1)
            begin
              state_ff  <= ST_ARMED;
              gapCnt_ff <= 32'h0;
            end
          end
          ST_ARMED:
          begin
            if (startCond)
            begin
              state_ff     <= ST_GATE;
              measBusyN_ff <= 1'b0;
              evtCnt_ff    <= 10'h0;
              ivOpen_ff    <= (func == FN_INTERVAL);
            end
          end
          ST_GATE:
          begin
            if (func == FN_INTERVAL && bFall)
              ivOpen_ff <= 1'b0;
            else if (func == FN_INTERVAL && aFall)
              ivOpen_ff <= 1'b1;
            if (refEvt)
              evtCnt_ff <= evtCnt_ff + 10'h1;
            if (stopCond)
            begin
              state_ff     <= ST_GAP;
              measBusyN_ff <= 1'b1;
              ivOpen_ff    <= 1'b0;
            end
          end
          default:
          begin
            state_ff     <= ST_ARMED;
            measBusyN_ff <= 1'b1;
          end
        endcase
    end
  end

  // Interval priming
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      primeStage_ff <= 2'h0;
    else if (ce)
    begin
      if (!clearN)
        primeStage_ff <= 2'h0;
      else if (stopNow && func == FN_INTERVAL && rangeSel == 2'h0)
        primeStage_ff <= 2'h0;
      else if (primeStage_ff == 2'h0 && aFall)
        primeStage_ff <= 2'h1;
      else if (primeStage_ff == 2'h1 && aRise)
        primeStage_ff <= 2'h0;
      else if (primeStage_ff == 2'h1 && bFall)
        primeStage_ff <= 2'h2;
    end
  end

  // Next decimal count with carry out on top
  logic [32:0] incVal;
  assign incVal = bcdInc(mainCnt_ff);

  // Main counter, overflow and display latches
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mainCnt_ff <= 32'h0;
      ovf_ff     <= 1'b0;
      dispLat_ff <= 32'h0;
      ovfLat_ff  <= 1'b0;
    end
    else if (ce)
    begin
      if (!clearN)
      begin
        mainCnt_ff <= 32'h0;
        ovf_ff     <= 1'b0;
        dispLat_ff <= 32'h0;
        ovfLat_ff  <= 1'b0;
      end
      else
      begin
        if (restart || (state_ff == ST_ARMED && startCond && func != FN_UNIT))
        begin
          mainCnt_ff <= 32'h0;
          ovf_ff     <= 1'b0;
        end
        else if (state_ff == ST_GATE && cntEvt)
        begin
          mainCnt_ff <= incVal[31:0];
          if (incVal[32])
            ovf_ff <= 1'b1;
        end
        if (stopNow || func == FN_UNIT)
        begin
          dispLat_ff <= mainCnt_ff;
          ovfLat_ff  <= ovf_ff;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Display multiplexer
  // ----------------------------------------------------------------
  logic [31:0] slotLim, blankLim, dataPoint;
  logic [3:0]  dpPos;
  assign slotLim   = oneMhz ? SlotTicks / PreDiv : SlotTicks;
  assign blankLim  = oneMhz ? BlankTicks / PreDiv : BlankTicks;
  assign dataPoint = blankLim - (oneMhz ? LagTicks / PreDiv : LagTicks);
  assign dpPos     = dpPosition(func, rangeSel, extEn, oneMhz);

  // Slot timing, digit data, strobe and decimal point
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slotCnt_ff     <= 32'h0;
      scanDigit_ff   <= 3'h7;
      bcdOut_ff      <= 4'h0;
      digitStrobe_ff <= 8'h00;
      dpOut_ff       <= 1'b0;
      lagCnt_ff      <= 8'h00;
    end
    else if (ce)
    begin
      if (lagCnt_ff != 8'hFF)
        lagCnt_ff <= lagCnt_ff + 8'h01;
      if (tbTick)
      begin
        if (slotCnt_ff == slotLim - 32'h1)
        begin
          slotCnt_ff     <= 32'h0;
          scanDigit_ff   <= scanDigit_ff - 3'h1;
          digitStrobe_ff <= 8'h00;
          dpOut_ff       <= 1'b0;
        end
        else
          slotCnt_ff <= slotCnt_ff + 32'h1;
        if (slotCnt_ff == dataPoint)
        begin
          bcdOut_ff <= dispLat_ff[scanDigit_ff*4 +: 4];
          lagCnt_ff <= 8'h00;
        end
        if (slotCnt_ff == blankLim)
          digitStrobe_ff <= 8'h01 << scanDigit_ff;
      end
      if (digitStrobe_ff != 8'h00 && !(tbTick && slotCnt_ff == slotLim - 32'h1))
        dpOut_ff <= (scanDigit_ff == 3'h7 && ovfLat_ff)
                    || (dpPos != 4'h0 && {1'b0, scanDigit_ff} == dpPos - 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  function automatic logic [31:0] regRead(input logic [7:0] a);
    case (a)
      `UCR_REG_CTRL:     regRead = {24'h0, ctrl_ff};
      `UCR_REG_STATUS:   regRead = {25'h0, scanDigit_ff, extSample_ff,
                                    primeStage_ff == 2'h2, ovfLat_ff, state_ff == ST_GATE};
      `UCR_REG_RESULT:   regRead = dispLat_ff;
      `UCR_REG_DISPINFO: regRead = {28'h0, dpPos};
      default:           regRead = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `UCR_REG_CTRL) || (a == `UCR_REG_STATUS)
             || (a == `UCR_REG_RESULT) || (a == `UCR_REG_DISPINFO);
  endfunction

  // Write channels and response
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awHeld_ff  <= 1'b0;
      wHeld_ff   <= 1'b0;
      awReady_ff <= 1'b1;
      wReady_ff  <= 1'b1;
      bValid_ff  <= 1'b0;
      bResp_ff   <= `UCR_RESP_OKAY;
      awAddr_ff  <= 8'h00;
      wData_ff   <= 32'h0;
      wStrb_ff   <= 4'h0;
      ctrl_ff    <= `UCR_CTRL_RESET;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && awReady_ff)
      begin
        awAddr_ff  <= s_axi_awaddr;
        awHeld_ff  <= 1'b1;
        awReady_ff <= 1'b0;
      end
      if (s_axi_wvalid && wReady_ff)
      begin
        wData_ff  <= s_axi_wdata;
        wStrb_ff  <= s_axi_wstrb;
        wHeld_ff  <= 1'b1;
        wReady_ff <= 1'b0;
      end
      if (wrFire)
      begin
        if (awAddr_ff == `UCR_REG_CTRL && wStrb_ff[0])
          ctrl_ff <= wData_ff[7:0];
        bResp_ff  <= mapped(awAddr_ff) ? `UCR_RESP_OKAY : `UCR_RESP_DECERR;
        bValid_ff <= 1'b1;
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
      end
      if (bValid_ff && s_axi_bready)
      begin
        bValid_ff  <= 1'b0;
        awReady_ff <= 1'b1;
        wReady_ff  <= 1'b1;
      end
    end
  end

  // Read channel
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      arReady_ff <= 1'b1;
      rValid_ff  <= 1'b0;
      rData_ff   <= 32'h0;
      rResp_ff   <= `UCR_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && arReady_ff)
      begin
        rData_ff   <= regRead(s_axi_araddr);
        rResp_ff   <= mapped(s_axi_araddr) ? `UCR_RESP_OKAY : `UCR_RESP_DECERR;
        rValid_ff  <= 1'b1;
        arReady_ff <= 1'b0;
      end
      else if (rValid_ff && s_axi_rready)
      begin
        rValid_ff  <= 1'b0;
        arReady_ff <= 1'b1;
      end
    end
  end

  // Output connections
  assign measBusyN     = measBusyN_ff;
  assign bcdOut        = bcdOut_ff;
  assign digitStrobe   = digitStrobe_ff;
  assign dpOut         = dpOut_ff;
  assign s_axi_awready = awReady_ff;
  assign s_axi_wready  = wReady_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rdata   = rData_ff;
  assign s_axi_rresp   = rResp_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence seqStrobeRise;
    (digitStrobe_ff == 8'h00) ##1 (digitStrobe_ff != 8'h00);
  endsequence

  chk_clear_zeroes: assert property (ce && !clearN |=> mainCnt_ff == 32'h0 && dispLat_ff == 32'h0 && measBusyN_ff)
    else $error("clear did not zero counter and display");
  chk_clear_holds: assert property ((ce && !clearN)[*2] |-> state_ff == ST_ARMED && !ovfLat_ff)
    else $error("clear did not hold control cleared");
  chk_busy_state: assert property (measBusyN_ff == (state_ff != ST_GATE))
    else $error("status output disagrees with measurement state");
  chk_strobe_onehot: assert property ($onehot0(digitStrobe_ff))
    else $error("more than one digit strobe active");
  chk_scan_down: assert property ($changed(scanDigit_ff) |-> scanDigit_ff == 3'($past(scanDigit_ff) - 3'h1))
    else $error("scan order not from digit eight downward");
  chk_strobe_lag: assert property (seqStrobeRise |-> lagCnt_ff >= 8'(LagMinClk) && lagCnt_ff <= 8'(LagMaxClk))
    else $error("strobe edge outside data lag window");
  chk_ext_trailing: assert property (extEn && func != FN_UNIT && $past(state_ff) == ST_ARMED && state_ff == ST_GATE
                                     |-> $past(refTick) && $past(extGateWindow))
    else $error("external window start off the reference edge");
  chk_ovf_point: assert property ($past(digitStrobe_ff[7]) && digitStrobe_ff[7] && $past(ovfLat_ff) |-> dpOut_ff)
    else $error("overflow not shown on digit eight point");
  chk_single_primed: assert property (func == FN_INTERVAL && rangeSel == 2'h0 && !extEn && $past(state_ff) == ST_ARMED
                                      && state_ff == ST_GATE |-> $past(primeStage_ff) == 2'h2)
    else $error("single interval started without priming");
  chk_gap_length: assert property ($past(state_ff) == ST_GAP && state_ff == ST_ARMED && $past(clearN) && !$past(restart)
                                   |-> $past(gapCnt_ff) == gapLim - 32'h1)
    else $error("gap between measurements wrong length");

endmodule

`default_nettype wire

//--- ucr_params.svh
`ifndef UCR_PARAMS_SVH
`define UCR_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define UCR_ADDR_W        8
`define UCR_REG_CTRL      8'h00
`define UCR_REG_STATUS    8'h04
`define UCR_REG_RESULT    8'h08
`define UCR_REG_DISPINFO  8'h0C
`define UCR_CTRL_RESET    8'h00

// Control fields
`define UCR_CTRL_FUNC_LSB 0
`define UCR_CTRL_RANGE_LSB 3
`define UCR_CTRL_EXTEN_BIT 5
`define UCR_CTRL_ONEMHZ_BIT 6

// Bus responses
`define UCR_RESP_OKAY     2'h0
`define UCR_RESP_DECERR   2'h3

// ----------------------------------------------------------------
// Timing figures and derived counts
// ----------------------------------------------------------------
`define UCR_CLK_HZ        10000000
`define UCR_OSC1M_HZ      1000000
`define UCR_REF_HZ        100
`define UCR_MUX_HZ        500
`define UCR_DIGITS        8
`define UCR_BLANK_US      6
`define UCR_LAG_US        4
`define UCR_LAG_MIN_US    2
`define UCR_LAG_MAX_US    6
`define UCR_GAP_MS        200
`define UCR_PRE_DIV       (`UCR_CLK_HZ / `UCR_OSC1M_HZ)
`define UCR_SLOT_TICKS    (`UCR_CLK_HZ / (`UCR_MUX_HZ * `UCR_DIGITS))
`define UCR_BLANK_TICKS   (`UCR_BLANK_US * (`UCR_CLK_HZ / 1000000))
`define UCR_LAG_TICKS     (`UCR_LAG_US * (`UCR_CLK_HZ / 1000000))
`define UCR_LAG_MIN_CLK   (`UCR_LAG_MIN_US * (`UCR_CLK_HZ / 1000000))
`define UCR_LAG_MAX_CLK   (`UCR_LAG_MAX_US * (`UCR_CLK_HZ / 1000000))

`endif

//--- ucr_pkg.sv
package ucr_pkg;

  // Measurement functions
  typedef enum logic [2:0] {FN_FREQ, FN_PERIOD, FN_RATIO, FN_INTERVAL, FN_UNIT, FN_OSC} ucr_func_t;

  // Measurement sequencing
  typedef enum logic [1:0] {ST_GAP, ST_ARMED, ST_GATE} ucr_state_t;

endpackage

//--- ucr_disp_model.sv
`timescale 1ns/1ps
`default_nettype none
module ucr_disp_model (
  // Display link
  input  wire logic       clk,
  input  wire logic [3:0] bcdOut,
  input  wire logic [7:0] digitStrobe,
  // Capture results
  output logic [7:0]      badCnt,
  output logic [7:0]      grabCnt
);
  logic [7:0] prevStb = 8'h00;
  logic [7:0] expStb = 8'h00;
  logic [3:0] prevBcd = 4'h0;
  int         stable = 0;
  int         blank = 0;
  initial
  begin
    badCnt = 8'h00;
    grabCnt = 8'h00;
  end
  // Latch on strobe leading edge, judge code, order and timing
  always @(posedge clk)
  begin
    if (digitStrobe != 8'h00 && (!$onehot(digitStrobe) || bcdOut > 4'h9))
      badCnt = badCnt + 8'h01;
    if (digitStrobe != 8'h00 && digitStrobe == prevStb && bcdOut != prevBcd)
      badCnt = badCnt + 8'h01;
    if (prevStb == 8'h00 && digitStrobe != 8'h00)
    begin
      grabCnt = grabCnt + 8'h01;
      if (expStb != 8'h00 && (digitStrobe != expStb || blank < 57 || blank > 62))
        badCnt = badCnt + 8'h01;
      if (stable < 18)
        badCnt = badCnt + 8'h01;
      expStb = {digitStrobe[0], digitStrobe[7:1]};
    end
    stable = (bcdOut == prevBcd) ? stable + 1 : 0;
    blank = (digitStrobe == 8'h00) ? blank + 1 : 0;
    prevStb = digitStrobe;
    prevBcd = bcdOut;
  end
endmodule
`default_nettype wire

//--- ucr_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ucr_params.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error %0t ns: value mismatch", $time); end end
module tb;
  logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, clearN = 1'b1;
  logic        chanA = 1'b0, chanB = 1'b0, extGateWindow = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        measBusyN, dpOut, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  bcdOut;
  logic [7:0]  digitStrobe, badCnt, grabCnt;
  logic [31:0] d, s_axi_rdata;
  int          err_total = 0, n_checks = 0, cnt, ex;
  ucr_top #(.REF_DIV_10M(100), .REF_DIV_1M(20), .GAP_10M(200), .GAP_1M(50)) dut (.*);
  ucr_disp_model model (.*);
  always #50 clk = ~clk;
  task automatic report_and_stop;
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo;
    err_total++;
    $display("Error %0t ns: wait ran out", $time);
    report_and_stop;
  endtask
  // Bus write, each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++)
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (s_axi_bvalid !== 1'b1) tmo;
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  // Bus read
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++)
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (s_axi_rvalid !== 1'b1) tmo;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic waitBusy(input logic lvl);
    for (int i = 0; i < 3000 && measBusyN !== lvl; i++) @(posedge clk);
    if (measBusyN !== lvl) tmo;
  endtask
  // Wait for one digit strobe, then let the point settle
  task automatic waitStb(input logic [7:0] s);
    for (int i = 0; i < 30000 && digitStrobe !== s; i++) @(posedge clk);
    if (digitStrobe !== s) tmo;
    repeat (2) @(posedge clk);
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`UCR_REG_CTRL);
    `CHK(d, 32'h0)
    rd(8'h40);
    `CHK(r, `UCR_RESP_DECERR)
    wr(8'h40, 32'h0);
    `CHK(r, `UCR_RESP_DECERR)
    waitBusy(1'b0);
    for (cnt = 0; cnt < 500 && measBusyN === 1'b0; cnt++) @(posedge clk);
    `CHK(cnt > 97 && cnt < 102, 1'b1)
    for (cnt = 0; cnt < 500 && measBusyN === 1'b1; cnt++) @(posedge clk);
    `CHK(cnt > 198 && cnt < 302, 1'b1)
    wr(`UCR_REG_CTRL, 32'h20);
    repeat (400) @(posedge clk);
    `CHK(measBusyN, 1'b1)
    extGateWindow <= 1'b1;
    waitBusy(1'b0);
    repeat (300) @(posedge clk);
    `CHK(measBusyN, 1'b0)
    extGateWindow <= 1'b0;
    waitBusy(1'b1);
    for (int f = 0; f < 6; f++)
      for (int g = 0; g < 5; g++)
      begin
        wr(`UCR_REG_CTRL, {26'h0, g == 4, g[1:0], f[2:0]});
        rd(`UCR_REG_DISPINFO);
        ex = (g == 4) ? 0 : (f == 2) ? g + 1 : (f == 4) ? 1 : g + 2;
        `CHK(d[3:0], ex[3:0])
      end
    wr(`UCR_REG_CTRL, 32'h4);
    repeat (20) @(posedge clk) chanA <= ~chanA;
    repeat (2) @(posedge clk);
    rd(`UCR_REG_RESULT);
    `CHK(d, 32'h10)
    clearN <= 1'b0;
    repeat (3) @(posedge clk);
    rd(`UCR_REG_RESULT);
    `CHK(d, 32'h0)
    `CHK(measBusyN, 1'b1)
    wr(`UCR_REG_CTRL, 32'h3);
    clearN <= 1'b1;
    chanA <= 1'b1;
    chanB <= 1'b1;
    repeat (3) @(posedge clk);
    chanA <= 1'b0;
    repeat (3) @(posedge clk);
    chanB <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(measBusyN, 1'b1)
    chanA <= 1'b1;
    chanB <= 1'b1;
    repeat (3) @(posedge clk);
    chanA <= 1'b0;
    repeat (25) @(posedge clk);
    `CHK(measBusyN, 1'b0)
    chanB <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(measBusyN, 1'b1)
    rd(`UCR_REG_RESULT);
    `CHK(d == 32'h24 || d == 32'h25, 1'b1)
    chanA <= 1'b1;
    chanB <= 1'b1;
    repeat (300) @(posedge clk);
    chanA <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(measBusyN, 1'b1)
    waitStb(8'h04);
    `CHK(dpOut, 1'b0)
    waitStb(8'h02);
    `CHK(dpOut, 1'b1)
    repeat (40000) @(posedge clk);
    `CHK(badCnt, 8'h00)
    `CHK(grabCnt > 8'h0F, 1'b1)
    report_and_stop;
  end
endmodule
`default_nettype wire
